// ==== axis_sampling_pkg.sv ====
// Constants for the axis position sampling readout
package axis_sampling_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int UPDATE_NS = 100;
  localparam int UPDATE_CYC = (UPDATE_NS / CLK_NS < 1) ? 1 : UPDATE_NS / CLK_NS;
  localparam int AUTO_STRETCH_NS = 150;
  localparam int AUTO_STRETCH_CYC = (AUTO_STRETCH_NS / CLK_NS < 1) ? 1 : AUTO_STRETCH_NS / CLK_NS;
  localparam int DRIVE_NS = 100;
  localparam int DRIVE_CYC = (DRIVE_NS + CLK_NS - 1) / CLK_NS;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int POS_W = 37;
  localparam int CAPS = 8;
  localparam int POS_CAPS = 6;
  localparam int TRIG = 4;
  localparam int PAR_W = 10;
  localparam int MAX_SHIFT = 5;
  // ---------------------------------------------------------------
  // Per-axis offsets (axis base = axis index in addr[9:8]) and board interrupt address
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_GEN = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_OUTCTL = 8'h10;
  localparam logic [7:0] OFF_SETUP = 8'h14;
  localparam logic [7:0] OFF_SRC = 8'h18;
  localparam logic [7:0] OFF_PRESET_LO = 8'h1c;
  localparam logic [7:0] OFF_PRESET_HI = 8'h20;
  localparam logic [7:0] OFF_POWER = 8'h24;
  localparam logic [7:0] OFF_LIVE_LO = 8'h28;
  localparam logic [7:0] OFF_LIVE_HI = 8'h2c;
  localparam logic [7:0] OFF_CAP = 8'h80;
  localparam logic [7:0] OFF_CAP_HI = 8'ha0;
  localparam logic [7:0] ALT_DELTA = 8'h40;
  localparam logic [11:0] ADDR_IRQ = 12'h400;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMD_DRIVE_BIT = 8;
  localparam int MODE_IEN_LSB = 8;
  localparam int OUTCTL_SHIFT_LSB = 8;
  localparam int SETUP_PAR_BIT = 4;
  localparam int SETUP_BUS_BIT = 5;
  localparam int SETUP_DRV_LSB = 8;
  localparam int IRQ_ON_BIT = 8;
  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SRC_SIM_CODE = 8'h55;
  localparam logic [15:0] POWER_5UW_CODE = 16'h0005;
  localparam logic [3:0] RST_TRIG_SYNC = 4'hf;
  localparam logic [2:0] RST_SHIFT = 3'h0;
  localparam logic [7:0] RST_VECTOR = 8'h00;
endpackage

// ==== axis_position_sampling_readout.sv ====
// Axis position capture, auto-sample and backplane position output
`timescale 1ns/10ps
// Function
// - 37-bit live position, selectable 32-bit slice
// - Six position, two velocity capture registers
// - Command bit copies live value into capture
// - Low trigger line n fills position n
// - Broadcast bit drives configured trigger lines low
// - Alternate read address 0x40 above capture
// - Alternate read captures then returns fresh value
// - Auto-sample completes within 150 ns
// - Status set on command or trigger capture, cleared by read
// - Enabled capture raises interrupt when armed
// - Paired position and velocity hardware capture
// - Hold-until-read blocks command and trigger overwrite of unread sample
// - Six-bit backplane axis address per axis
// - Board-wide backplane output enable bit
// - Matching address and low strobe drive position
// - Backplane position refreshed every 100 ns
// - Setup bit 4 enables ten-bit parallel outputs
// - Source code 0x55 forces zero phase
// - Preset write loads position counter
// - Simulated channel reads 5 microwatt power
// - Last axis phase step sent downstream as reference phase, even when forced
module axis_position_sampling_readout #(
  parameter int AXES = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [AXES*8-1:0] phase_step_in,
  input wire logic [AXES*32-1:0] power_in,
  input wire logic [AXES-1:0] axis_error_in,
  input wire logic [3:0] sample_n_in,
  output logic [3:0] sample_n_out,
  output logic [3:0] sample_oe_out,
  input wire logic [5:0] axis_select_address_in,
  input wire logic bp_read_n_in,
  output logic [31:0] bp_pos_out,
  output logic bp_err_out,
  output logic bp_oe_out,
  output logic [AXES*10-1:0] par_pos_out,
  output logic [7:0] ref_phase_out,
  output logic irq_out,
  output logic [7:0] irq_vector_out
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (AXES < 1 || AXES > 4) begin : g_bad_axes
    $error("AXES must be 1 to 4");
  end
  if (axis_sampling_pkg::AUTO_STRETCH_CYC < 1) begin : g_bad_stretch
    $error("Auto-sample stretch below one cycle");
  end

  localparam int PW = axis_sampling_pkg::POS_W;
  localparam int NC = axis_sampling_pkg::CAPS;

  typedef struct packed {
    logic [AXES-1:0][PW-1:0] pos;
    logic [AXES-1:0][PW-1:0] vel;
    logic [AXES-1:0][NC-1:0][PW-1:0] cap;
    logic [AXES-1:0][NC-1:0] stat;
    logic [AXES-1:0][NC-1:0] hold;
    logic [AXES-1:0][NC-1:0] ien;
    logic [AXES-1:0][1:0] pair;
    logic [AXES-1:0][5:0] bp_addr;
    logic [AXES-1:0][2:0] shift;
    logic [AXES-1:0] sim;
    logic [AXES-1:0][31:0] preset_lo;
    logic [3:0] drv_mask;
    logic par_en;
    logic bus_en;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [1:0] drv_cnt;
    logic [1:0] div;
    logic [7:0] vec;
    logic irq_on;
    logic [31:0] rdata;
    logic [31:0] bp_pos;
    logic bp_err;
    logic [AXES*10-1:0] par;
    logic [7:0] ref_phase;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] slice32(input logic [PW-1:0] v, input logic [2:0] sh);
    logic [PW-1:0] t;
    logic [2:0] s;
    s = (sh > 3'(axis_sampling_pkg::MAX_SHIFT)) ? 3'(axis_sampling_pkg::MAX_SHIFT) : sh;
    t = v >> s;
    return t[31:0];
  endfunction

  function automatic logic [PW-1:0] sext(input logic [7:0] v);
    return {{(PW-8){v[7]}}, v};
  endfunction

  logic tick;
  logic [3:0] trig_fall;
  logic axis_hit;
  logic bp_match;
  logic [1:0] ax;
  logic [7:0] off;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [PW-1:0] step;
    logic [PW-1:0] src;
    logic req;
    logic alt;
    logic set;
    logic clr;
    nxt_state = state_ff;
    step = '0;
    src = '0;
    req = 1'b0;
    alt = 1'b0;
    set = 1'b0;
    clr = 1'b0;
    ax = addr_in[9:8];
    off = addr_in[7:0];
    axis_hit = (addr_in[11:10] == 2'h0) && (32'(ax) < AXES);
    tick = (state_ff.div == 2'(axis_sampling_pkg::UPDATE_CYC - 1));
    nxt_state.div = tick ? 2'h0 : state_ff.div + 2'h1;
    // Trigger synchroniser, edge taken from the second and third stages
    nxt_state.s1 = sample_n_in;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    trig_fall = state_ff.s3 & ~state_ff.s2;
    nxt_state.rdata = 32'h0;
    if (state_ff.drv_cnt != 2'h0) begin
      nxt_state.drv_cnt = state_ff.drv_cnt - 2'h1;
    end
    if (tick) begin
      nxt_state.ref_phase = phase_step_in[(AXES-1)*8 +: 8];
    end
    // Board interrupt register
    if (wr_in && addr_in == axis_sampling_pkg::ADDR_IRQ) begin
      nxt_state.vec = wdata_in[7:0];
      nxt_state.irq_on = wdata_in[axis_sampling_pkg::IRQ_ON_BIT];
    end
    if (rd_in && addr_in == axis_sampling_pkg::ADDR_IRQ) begin
      nxt_state.rdata = {23'h0, state_ff.irq_on, state_ff.vec};
    end
    for (int a = 0; a < AXES; a++) begin
      // Live position counter
      step = state_ff.sim[a] ? '0 : sext(phase_step_in[a*8 +: 8]);
      if (tick) begin
        nxt_state.pos[a] = state_ff.pos[a] + step;
        nxt_state.vel[a] = step;
      end
      if (wr_in && axis_hit && ax == 2'(a)) begin
        case (off)
          axis_sampling_pkg::OFF_CMD: begin
            if (wdata_in[axis_sampling_pkg::CMD_DRIVE_BIT]) begin
              nxt_state.drv_cnt = 2'(axis_sampling_pkg::DRIVE_CYC);
            end
          end
          axis_sampling_pkg::OFF_GEN: nxt_state.pair[a] = wdata_in[1:0];
          axis_sampling_pkg::OFF_MODE: begin
            nxt_state.hold[a] = wdata_in[NC-1:0];
            nxt_state.ien[a] = wdata_in[axis_sampling_pkg::MODE_IEN_LSB +: NC];
          end
          axis_sampling_pkg::OFF_OUTCTL: begin
            nxt_state.bp_addr[a] = wdata_in[5:0];
            nxt_state.shift[a] = wdata_in[axis_sampling_pkg::OUTCTL_SHIFT_LSB +: 3];
          end
          axis_sampling_pkg::OFF_SETUP: begin
            if (a == 0) begin
              nxt_state.par_en = wdata_in[axis_sampling_pkg::SETUP_PAR_BIT];
              nxt_state.bus_en = wdata_in[axis_sampling_pkg::SETUP_BUS_BIT];
              nxt_state.drv_mask = wdata_in[axis_sampling_pkg::SETUP_DRV_LSB +: 4];
            end
          end
          axis_sampling_pkg::OFF_SRC: begin
            nxt_state.sim[a] = (wdata_in[7:0] == axis_sampling_pkg::SRC_SIM_CODE);
          end
          axis_sampling_pkg::OFF_PRESET_LO: nxt_state.preset_lo[a] = wdata_in;
          axis_sampling_pkg::OFF_PRESET_HI: begin
            nxt_state.pos[a] = {wdata_in[PW-33:0], state_ff.preset_lo[a]};
          end
          default: ;
        endcase
      end
      // Capture registers
      for (int k = 0; k < NC; k++) begin
        src = (k < axis_sampling_pkg::POS_CAPS) ? state_ff.pos[a] : state_ff.vel[a];
        req = wr_in && axis_hit && ax == 2'(a) && off == axis_sampling_pkg::OFF_CMD && wdata_in[k];
        if (k < axis_sampling_pkg::TRIG) begin
          req = req | trig_fall[k];
        end
        if (k == 6) begin
          req = req | (state_ff.pair[a][0] & trig_fall[0]);
        end
        if (k == 7) begin
          req = req | (state_ff.pair[a][1] & trig_fall[1]);
        end
        alt = rd_in && axis_hit && ax == 2'(a) && off == axis_sampling_pkg::OFF_CAP + axis_sampling_pkg::ALT_DELTA + 8'(4*k);
        clr = rd_in && axis_hit && ax == 2'(a) && off == axis_sampling_pkg::OFF_CAP + 8'(4*k);
        set = 1'b0;
        if (alt) begin
          nxt_state.cap[a][k] = src;
          nxt_state.rdata = slice32(src, state_ff.shift[a]);
        end else if (req && !(state_ff.hold[a][k] && state_ff.stat[a][k])) begin
          nxt_state.cap[a][k] = src;
          set = 1'b1;
        end
        nxt_state.stat[a][k] = (state_ff.stat[a][k] & ~clr) | set;
        if (clr) begin
          nxt_state.rdata = slice32(state_ff.cap[a][k], state_ff.shift[a]);
        end
        if (rd_in && axis_hit && ax == 2'(a) && off == axis_sampling_pkg::OFF_CAP_HI + 8'(4*k)) begin
          nxt_state.rdata = 32'(state_ff.cap[a][k][PW-1:32]);
        end
      end
      // Register reads
      if (rd_in && axis_hit && ax == 2'(a)) begin
        case (off)
          axis_sampling_pkg::OFF_GEN: nxt_state.rdata = {30'h0, state_ff.pair[a]};
          axis_sampling_pkg::OFF_MODE: nxt_state.rdata = {16'h0, state_ff.ien[a], state_ff.hold[a]};
          axis_sampling_pkg::OFF_STAT: nxt_state.rdata = {24'h0, state_ff.stat[a]};
          axis_sampling_pkg::OFF_OUTCTL: nxt_state.rdata = {21'h0, state_ff.shift[a], 2'h0, state_ff.bp_addr[a]};
          axis_sampling_pkg::OFF_SETUP: begin
            if (a == 0) begin
              nxt_state.rdata = {20'h0, state_ff.drv_mask, 2'h0, state_ff.bus_en, state_ff.par_en, 4'h0};
            end
          end
          axis_sampling_pkg::OFF_SRC: nxt_state.rdata = {24'h0, state_ff.sim[a] ? axis_sampling_pkg::SRC_SIM_CODE : 8'h00};
          axis_sampling_pkg::OFF_POWER: begin
            nxt_state.rdata = state_ff.sim[a] ? {2{axis_sampling_pkg::POWER_5UW_CODE}} : power_in[a*32 +: 32];
          end
          axis_sampling_pkg::OFF_LIVE_LO: nxt_state.rdata = slice32(state_ff.pos[a], state_ff.shift[a]);
          axis_sampling_pkg::OFF_LIVE_HI: nxt_state.rdata = 32'(state_ff.pos[a][PW-1:32]);
          default: ;
        endcase
      end
      // Parallel ten-bit outputs
      if (tick) begin
        nxt_state.par[a*10 +: 10] = state_ff.par_en ? state_ff.pos[a][9:0] : 10'h0;
      end
    end
    // Addressed backplane position
    bp_match = 1'b0;
    for (int a = 0; a < AXES; a++) begin
      if (state_ff.bp_addr[a] == axis_select_address_in) begin
        bp_match = 1'b1;
        if (tick) begin
          nxt_state.bp_pos = slice32(state_ff.pos[a], state_ff.shift[a]);
          nxt_state.bp_err = axis_error_in[a];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= '0;
      state_ff.s1 <= axis_sampling_pkg::RST_TRIG_SYNC;
      state_ff.s2 <= axis_sampling_pkg::RST_TRIG_SYNC;
      state_ff.s3 <= axis_sampling_pkg::RST_TRIG_SYNC;
      state_ff.shift <= {AXES{axis_sampling_pkg::RST_SHIFT}};
      state_ff.vec <= axis_sampling_pkg::RST_VECTOR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_out = state_ff.rdata;
  assign sample_n_out = 4'h0;
  assign sample_oe_out = state_ff.drv_mask & {4{state_ff.drv_cnt != 2'h0}};
  assign bp_pos_out = state_ff.bp_pos;
  assign bp_err_out = state_ff.bp_err;
  assign bp_oe_out = state_ff.bus_en && bp_match && !bp_read_n_in;
  assign par_pos_out = state_ff.par;
  assign ref_phase_out = state_ff.ref_phase;
  assign irq_out = state_ff.irq_on && (state_ff.vec != 8'h00) && |(state_ff.stat & state_ff.ien);
  assign irq_vector_out = state_ff.vec;
endmodule // axis_position_sampling_readout

// ==== axis_sampling_properties.sv ====
// Port checker for the axis position sampling readout
`timescale 1ns/10ps
module axis_sampling_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [3:0] sample_n_out,
  input wire logic [3:0] sample_oe_out,
  input wire logic bp_read_n_in,
  input wire logic [31:0] bp_pos_out,
  input wire logic bp_oe_out,
  input wire logic irq_out,
  input wire logic [7:0] irq_vector_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  bp_strobe_a: assert property (bp_oe_out |-> !bp_read_n_in) else $error("bus driven without read strobe");
  bp_release_a: assert property (bp_read_n_in |-> !bp_oe_out) else $error("bus driven after strobe release");
  bp_refresh_a: assert property (bp_oe_out && $changed(bp_pos_out) |=> $stable(bp_pos_out))
    else $error("backplane position changed faster than refresh");
  drive_low_a: assert property (|sample_oe_out |-> sample_n_out == 4'h0) else $error("trigger drive not low");
  drive_len_a: assert property ($rose(|sample_oe_out) |=> (|sample_oe_out) ##1 !(|sample_oe_out))
    else $error("trigger drive length wrong");
  drive_cause_a: assert property ($rose(|sample_oe_out) |-> $past(wr_in) && $past(wdata_in[8]))
    else $error("trigger drive without command");
  irq_vector_a: assert property (irq_out |-> irq_vector_out != 8'h00) else $error("interrupt without vector");
  rdata_slot_a: assert property (rdata_out != 32'h0 |-> $past(rd_in)) else $error("read data outside slot");
  cover property ($rose(irq_out));
  cover property (bp_oe_out);
  cover property ($rose(|sample_oe_out));
endmodule // axis_sampling_checker
bind axis_position_sampling_readout axis_sampling_checker u_axis_sampling_checker (.clock_in, .rst_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .sample_n_out, .sample_oe_out, .bp_read_n_in, .bp_pos_out, .bp_oe_out, .irq_out,
  .irq_vector_out);

// ==== bp_partner.sv ====
// Backplane capture hardware model with pulled-up trigger lines
`timescale 1ns/10ps
module bp_partner (
  input wire logic clock_in,
  input wire logic rd_req_in,
  input wire logic [5:0] req_addr_in,
  input wire logic [3:0] trig_in,
  input wire logic [3:0] sample_oe_in,
  output logic [5:0] axis_select_address_out,
  output logic bp_read_n_out,
  output logic [3:0] sample_n_out
);
  logic [5:0] idle_ff = 6'h15;
  // Released address lines wander every cycle
  always_ff @(posedge clock_in) begin
    idle_ff <= idle_ff + 6'h01;
  end
  assign bp_read_n_out = ~rd_req_in;
  assign axis_select_address_out = rd_req_in ? req_addr_in : idle_ff;
  assign sample_n_out = ~(trig_in | sample_oe_in);
endmodule // bp_partner

// ==== tb_axis_position_sampling_readout.sv ====
// Self-checking bench for the axis position sampling readout
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_axis_position_sampling_readout;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0, rdata_out, bp_pos_out, exp_v, phase_step_in = 32'h0, seed = 32'h2b;
  logic wr_in = 1'b0, rd_in = 1'b0, rd_seen = 1'b0, rd_req = 1'b0, bp_read_n, bp_err_out, bp_oe_out, irq_out;
  logic [127:0] power_in = 128'h0;
  logic [3:0] sample_n_in, sample_n_out, sample_oe_out, trig = 4'h0, axis_err = 4'h1;
  logic [5:0] sel_addr, req_addr = 6'h00;
  logic [39:0] par_pos_out;
  logic [7:0] ref_phase_out, irq_vector_out;
  logic [36:0] pos, prev;
  logic [31:0] exp_q[$];
  int fails = 0;
  int num_checks = 0;
  axis_position_sampling_readout u_axis_position_sampling_readout (.clock_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .phase_step_in, .power_in, .axis_error_in(axis_err), .sample_n_in, .sample_n_out,
    .sample_oe_out, .axis_select_address_in(sel_addr), .bp_read_n_in(bp_read_n), .bp_pos_out, .bp_err_out,
    .bp_oe_out, .par_pos_out, .ref_phase_out, .irq_out, .irq_vector_out);
  bp_partner u_bp_partner (.clock_in, .rd_req_in(rd_req), .req_addr_in(req_addr), .trig_in(trig),
    .sample_oe_in(sample_oe_out), .axis_select_address_out(sel_addr), .bp_read_n_out(bp_read_n),
    .sample_n_out(sample_n_in));
  initial forever #25 clock_in = ~clock_in;
  always @(posedge clock_in) rd_seen <= rd_in;
  always @(negedge clock_in) begin
    if (rd_seen) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx;
      `CHK(rdata_out, exp_v)
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    exp_q.push_back(e);
    @(posedge clock_in);
  endtask
  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask
  task automatic new_pos();
    prev = pos;
    seed = lfsr(seed);
    pos[36:32] = seed[4:0];
    seed = lfsr(seed);
    pos[31:0] = seed;
    wr(12'h01c, pos[31:0]);
    wr(12'h020, {27'h0, pos[36:32]});
    idle(2);
  endtask
  task automatic end_of_test();
    if (exp_q.size() != 0) fails++;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_in);
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    seed = lfsr(seed);
    phase_step_in <= seed;
    seed = lfsr(seed);
    power_in <= {4{seed}};
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    wr(12'h018, 32'h55);
    wr(12'h318, 32'h55);
    wr(12'h010, 32'h32a);
    new_pos();
    rd(12'h028, pos[34:3]);
    rd(12'h02c, {27'h0, pos[36:32]});
    rd(12'h024, 32'h00050005);
    rd(12'h3fc, 32'h0);
    `CHK(ref_phase_out, phase_step_in[31:24])
    wr(12'h000, 32'h3f);
    rd(12'h00c, 32'h3f);
    for (int k = 0; k < 6; k++) rd(12'h080 + 12'(4 * k), pos[34:3]);
    rd(12'h0a0, {27'h0, pos[36:32]});
    rd(12'h00c, 32'h0);
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h1);
    new_pos();
    wr(12'h000, 32'h1);
    rd(12'h080, prev[34:3]);
    wr(12'h000, 32'h1);
    rd(12'h080, pos[34:3]);
    new_pos();
    rd(12'h0c4, pos[34:3]);
    rd(12'h084, pos[34:3]);
    rd(12'h00c, 32'h0);
    wr(12'h008, 32'h400);
    wr(12'h400, 32'h15a);
    trig <= 4'h4;
    idle(6);
    trig <= 4'h0;
    idle(2);
    #5;
    `CHK(irq_out, 1'b1)
    `CHK(irq_vector_out, 8'h5a)
    rd(12'h088, pos[34:3]);
    idle(2);
    #5;
    `CHK(irq_out, 1'b0)
    new_pos();
    wr(12'h014, 32'hf30);
    wr(12'h000, 32'h100);
    idle(8);
    for (int k = 0; k < 4; k++) rd(12'h080 + 12'(4 * k), pos[34:3]);
    idle(1);
    #5;
    `CHK(par_pos_out[9:0], pos[9:0])
    req_addr <= 6'h2b;
    rd_req <= 1'b1;
    idle(3);
    #5;
    `CHK(bp_oe_out, 1'b0)
    req_addr <= 6'h2a;
    idle(4);
    #5;
    `CHK(bp_oe_out, 1'b1)
    `CHK(bp_pos_out, pos[34:3])
    `CHK(bp_err_out, axis_err[0])
    rd_req <= 1'b0;
    idle(1);
    #5;
    `CHK(bp_oe_out, 1'b0)
    @(posedge clock_in);
    wr(12'h004, 32'h1);
    trig <= 4'h1;
    idle(6);
    trig <= 4'h0;
    idle(2);
    rd(12'h00c, 32'h41);
    idle(1);
    end_of_test();
  end
endmodule // tb_axis_position_sampling_readout
